//--- src/nrps_cycle.sv
// one port cycle: strobe low then high, byte latched by the device on rising edge
module nrps_cycle
  import nrps_pkg::*;
(
  input  wire logic         CLK_SYS_I,
  input  wire logic         RESET_I,
  input  wire logic         start_i,
  input  nrps_pkg::nrps_cyc_type kind_i,
  input  wire logic [7:0]   byte_i,
  input  wire logic [7:0]   dq_i,
  output nrps_pkg::nrps_pins_type pins_o,
  output logic              done_o,
  output logic [7:0]        rbyte_o
);
  import nrps_pkg::*;

  typedef enum logic [1:0] { S_IDLE, S_LOW, S_HIGH } nrps_cst_type;
  nrps_cst_type st_q;
  logic [3:0]   cnt_q;
  nrps_cyc_type kind_q;
  logic [7:0]   byte_q;

  // ==========================================================
  // strobe timing
  always_ff @(posedge CLK_SYS_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      st_q   <= S_IDLE;
      cnt_q  <= 4'h0;
      kind_q <= CY_CMD;
      byte_q <= 8'h00;
    end
    else
    begin
      unique case (st_q)
        S_IDLE:
          if (start_i)
          begin
            st_q   <= S_LOW;
            kind_q <= kind_i;
            byte_q <= byte_i;
            cnt_q  <= 4'(STROBE_LOW_CYC - 1);
          end
        S_LOW:
          if (cnt_q == 4'h0)
          begin
            st_q  <= S_HIGH;
            cnt_q <= 4'(STROBE_HIGH_CYC - 1);
          end
          else
            cnt_q <= cnt_q - 4'h1;
        S_HIGH:
          if (cnt_q == 4'h0)
            st_q <= S_IDLE;
          else
            cnt_q <= cnt_q - 4'h1;
      endcase
    end
  end

  // sample read data at end of the low phase, strobe still low
  always_ff @(posedge CLK_SYS_I or posedge RESET_I)
  begin
    if (RESET_I)
      rbyte_o <= 8'h00;
    else if (st_q == S_LOW && cnt_q == 4'h0 && kind_q == CY_RDATA)
      rbyte_o <= dq_i;
  end

  assign done_o = (st_q == S_HIGH) && (cnt_q == 4'h0);

  // ==========================================================
  // pins; latch lines held through the whole cycle
  always_comb
  begin
    pins_o               = '0;
    pins_o.ce_n          = 1'b0;
    pins_o.we_n          = !(st_q == S_LOW && kind_q != CY_RDATA);
    pins_o.read_strobe_n = !(st_q == S_LOW && kind_q == CY_RDATA);
    pins_o.wp_n          = 1'b1;
    pins_o.cle           = (st_q != S_IDLE) && (kind_q == CY_CMD);
    pins_o.ale           = (st_q != S_IDLE) && (kind_q == CY_ADDR);
    pins_o.dq_out        = byte_q;
    pins_o.dq_oe_n       = (st_q == S_IDLE) || (kind_q == CY_RDATA);
  end

  // data cycles raise neither latch line, so only both together is illegal
  a_latch_stable : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(pins_o.we_n) |-> $stable(pins_o.cle) && $stable(pins_o.ale) && !(pins_o.cle && pins_o.ale))
    else $error("latch lines moved or both set");
  a_read_no_drive : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    !pins_o.read_strobe_n |-> pins_o.dq_oe_n && pins_o.we_n) else $error("drive during read");
endmodule

//--- src/nrps_host.sv
// Contract
// - read: setup, five address bytes, confirm
// - host restarts cache read on block change
// - first cache read only after ready
// - one block per district, same page
// - per-district setup plus address, then confirm
// - write protect held high during reads
// - only status or reset between districts
// - address: two column, three row bytes
// - strobes high and only status/reset while busy
module nrps_host
  import nrps_pkg::*;
(
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESET_I,
  input  wire logic              REQ_VALID_I,
  output logic                   REQ_READY_O,
  input  nrps_pkg::nrps_req_type REQ_I,
  input  wire logic [7:0]        WDATA_I,
  output logic                   WDATA_READY_O,
  output logic [7:0]             RDATA_O,
  output logic                   RDATA_VALID_O,
  output logic                   STATUS_FAIL_O,
  output logic                   DONE_O,
  input  wire logic [7:0]        DQ_I,
  input  wire logic              READY_BUSY_OUT_I,
  output nrps_pkg::nrps_pins_type PINS_O
);
  import nrps_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE, H_CMD1, H_ADDR, H_WDATA, H_CMD2, H_SETTLE, H_WAIT, H_RDATA, H_DONE
  } nrps_hst_type;

  nrps_hst_type st_q;
  nrps_req_type req_q;
  logic [2:0]   acnt_q;
  logic [COL_BITS:0] dcnt_q;
  logic [3:0]   wcnt_q;
  logic         second_q;
  logic         cyc_start;
  nrps_cyc_type cyc_kind;
  logic [7:0]   cyc_byte;
  logic         cyc_done;
  logic [7:0]   cyc_rbyte;
  logic [ROW_BITS-1:0] chain_row_q;

  // address byte n: column low/high, then row bytes; upper column bits low
  function automatic logic [7:0] addr_byte(input logic [2:0] n, input logic [COL_BITS-1:0] col,
                                           input logic [ROW_BITS-1:0] row);
    unique case (n)
      3'd0:    addr_byte = col[7:0];
      3'd1:    addr_byte = {4'h0, col[11:8]};
      3'd2:    addr_byte = row[7:0];
      3'd3:    addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]};
    endcase
  endfunction

  // first command byte of each operation
  function automatic logic [7:0] first_cmd(input nrps_op_type op, input logic second);
    unique case (op)
      OP_READ:       first_cmd = CMD_READ_SETUP;
      OP_CACHE_NEXT: first_cmd = CMD_CACHE_READ;
      OP_CACHE_LAST: first_cmd = CMD_CACHE_LAST;
      OP_MULTI_READ: first_cmd = CMD_MULTI_READ;
      OP_PROGRAM:    first_cmd = CMD_PROG_SETUP;
      OP_MULTI_PROG: first_cmd = second ? CMD_PROG_SETUP2 : CMD_PROG_SETUP;
      OP_STATUS:     first_cmd = CMD_STATUS;
      default:       first_cmd = CMD_RESET;
    endcase
  endfunction

  wire single_cmd = (req_q.op == OP_CACHE_NEXT) || (req_q.op == OP_CACHE_LAST) ||
                    (req_q.op == OP_STATUS) || (req_q.op == OP_RESET);
  wire is_prog    = (req_q.op == OP_PROGRAM) || (req_q.op == OP_MULTI_PROG);
  wire reads_back = (req_q.op == OP_READ) || (req_q.op == OP_MULTI_READ) ||
                    (req_q.op == OP_CACHE_NEXT) || (req_q.op == OP_CACHE_LAST);
  // multi read sends both district addresses before one confirm
  wire multi_first = (req_q.op == OP_MULTI_READ || req_q.op == OP_MULTI_PROG) && !second_q;
  // page that the next cache command would fetch
  wire [ROW_BITS-1:0] next_row = chain_row_q + 1'b1;
  wire chain_op = (REQ_I.op == OP_CACHE_NEXT) || (REQ_I.op == OP_CACHE_LAST);

  // ==========================================================
  // cache chain tracking; a chain may not run past the end of its block
  always_ff @(posedge CLK_SYS_I or posedge RESET_I)
  begin
    if (RESET_I)
      chain_row_q <= '0;
    else if (st_q == H_IDLE && REQ_VALID_I && READY_BUSY_OUT_I && (chain_op || REQ_I.op == OP_READ))
      chain_row_q <= (REQ_I.op == OP_READ) ? REQ_I.row : next_row;
  end

  // ==========================================================
  // sequence state machine
  always_ff @(posedge CLK_SYS_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      st_q     <= H_IDLE;
      req_q    <= '0;
      acnt_q   <= 3'd0;
      dcnt_q   <= '0;
      wcnt_q   <= 4'h0;
      second_q <= 1'b0;
    end
    else
    begin
      unique case (st_q)
        H_IDLE:
          if (REQ_VALID_I && READY_BUSY_OUT_I)
          begin
            req_q    <= REQ_I;
            // limitation: the second district always reuses the first page
            req_q.row2 <= {REQ_I.row2[ROW_BITS-1:PAGE_BITS], REQ_I.row[PAGE_BITS-1:0]};
            second_q <= 1'b0;
            st_q     <= H_CMD1;
            // a chain that would leave its block restarts as a plain read
            if (chain_op && next_row[PAGE_BITS-1:0] == '0)
            begin
              req_q.op     <= OP_READ;
              req_q.column <= '0;
              req_q.row    <= next_row;
            end
          end
        H_CMD1:
          if (cyc_done)
          begin
            acnt_q <= 3'd0;
            dcnt_q <= req_q.count;
            if (req_q.op == OP_STATUS)
              st_q <= H_RDATA;
            else if (single_cmd)
              st_q <= H_SETTLE;
            else
              st_q <= H_ADDR;
          end
        H_ADDR:
          if (cyc_done)
          begin
            acnt_q <= acnt_q + 3'd1;
            if (acnt_q == 3'(COL_CYCLES + ROW_CYCLES - 1))
              st_q <= is_prog ? H_WDATA : (multi_first ? H_CMD1 : H_CMD2);
            if (acnt_q == 3'(COL_CYCLES + ROW_CYCLES - 1) && multi_first && !is_prog)
              second_q <= 1'b1;
          end
        H_WDATA:
          if (dcnt_q == '0)
            st_q <= H_CMD2;
          else if (cyc_done)
            dcnt_q <= dcnt_q - 1'b1;
        H_CMD2:
          if (cyc_done)
            st_q <= H_SETTLE;
        H_SETTLE:
          if (wcnt_q == 4'(BUSY_SETTLE_CYC - 1))
            st_q <= H_WAIT;
        H_WAIT:
          if (READY_BUSY_OUT_I)
          begin
            dcnt_q <= req_q.count;
            if (multi_first)
            begin
              second_q <= 1'b1;
              req_q.row <= req_q.row2;
              st_q     <= H_CMD1;
            end
            else if (reads_back)
              st_q <= H_RDATA;
            else if (req_q.op == OP_STATUS || req_q.op == OP_RESET)
              st_q <= H_DONE;
            else
              st_q <= H_CMD1;
            if (is_prog && !multi_first)
            begin
              req_q.op <= OP_STATUS;
              st_q     <= H_CMD1;
            end
          end
        H_RDATA:
          if (req_q.op == OP_STATUS ? cyc_done : (dcnt_q == '0))
            st_q <= H_DONE;
          else if (cyc_done)
            dcnt_q <= dcnt_q - 1'b1;
        H_DONE:
          st_q <= H_IDLE;
        default:
          st_q <= H_IDLE;
      endcase
      wcnt_q <= (st_q == H_SETTLE) ? wcnt_q + 4'h1 : 4'h0;
    end
  end

  // multi program second address swapped into row before second setup
  always_comb
  begin
    cyc_start = 1'b0;
    cyc_kind  = CY_CMD;
    cyc_byte  = 8'h00;
    unique case (st_q)
      H_CMD1:  begin cyc_start = 1'b1; cyc_byte = first_cmd(req_q.op, second_q); end
      H_ADDR:  begin cyc_start = 1'b1; cyc_kind = CY_ADDR;
                     cyc_byte = addr_byte(acnt_q, req_q.column, second_q ? req_q.row2 : req_q.row); end
      H_WDATA: begin cyc_start = (dcnt_q != '0); cyc_kind = CY_WDATA; cyc_byte = WDATA_I; end
      H_CMD2:  begin cyc_start = 1'b1;
                     cyc_byte = (req_q.op == OP_MULTI_PROG && !second_q) ? CMD_PROG_FIRST :
                                is_prog ? CMD_PROG_CONFIRM : CMD_READ_CONFIRM; end
      H_RDATA: begin cyc_start = (req_q.op == OP_STATUS) || (dcnt_q != '0); cyc_kind = CY_RDATA; end
      default: ;
    endcase
  end

  nrps_cycle u_cycle (
    .CLK_SYS_I (CLK_SYS_I),
    .RESET_I   (RESET_I),
    .start_i   (cyc_start),
    .kind_i    (cyc_kind),
    .byte_i    (cyc_byte),
    .dq_i      (DQ_I),
    .pins_o    (PINS_O),
    .done_o    (cyc_done),
    .rbyte_o   (cyc_rbyte)
  );

  // ==========================================================
  // user side: read data, status and completion
  always_ff @(posedge CLK_SYS_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      RDATA_O       <= 8'h00;
      RDATA_VALID_O <= 1'b0;
      STATUS_FAIL_O <= 1'b0;
      DONE_O        <= 1'b0;
    end
    else
    begin
      RDATA_VALID_O <= (st_q == H_RDATA) && cyc_done;
      if ((st_q == H_RDATA) && cyc_done)
        RDATA_O <= cyc_rbyte;
      if ((st_q == H_RDATA) && cyc_done && req_q.op == OP_STATUS)
        STATUS_FAIL_O <= cyc_rbyte[0];
      DONE_O <= (st_q == H_DONE);
    end
  end

  assign REQ_READY_O   = (st_q == H_IDLE) && READY_BUSY_OUT_I;
  assign WDATA_READY_O = (st_q == H_WDATA) && cyc_done && (dcnt_q != '0);

  // ==========================================================
  // checks
  a_busy_strobes_hi : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (st_q == H_WAIT && !READY_BUSY_OUT_I) |-> PINS_O.we_n && PINS_O.read_strobe_n)
    else $error("strobe active while busy");
  a_addr_five_bytes : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (st_q == H_ADDR && cyc_done && acnt_q == 3'd4) |=> st_q != H_ADDR)
    else $error("address not five bytes");
  a_col_hi_zero : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (st_q == H_ADDR && acnt_q == 3'd1) |-> cyc_byte[7:4] == 4'h0) else $error("column high nibble set");
  a_wait_ready : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (st_q == H_IDLE && $past(st_q) == H_IDLE) ##1 st_q == H_CMD1 |-> $past(READY_BUSY_OUT_I))
    else $error("started while busy");
  a_confirm_byte : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (st_q == H_CMD2 && req_q.op == OP_READ) |-> cyc_byte == CMD_READ_CONFIRM) else $error("bad confirm");
  // settle phase: four cycles of waiting, then the ready watch
  sequence s_settle_run;
    (st_q == H_SETTLE) [*4] ##1 (st_q == H_WAIT);
  endsequence
  a_settle_len : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $rose(st_q == H_SETTLE) |-> s_settle_run) else $error("settle length");
  a_multi_cmd : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (st_q == H_CMD2 && req_q.op == OP_MULTI_PROG && !second_q) |-> cyc_byte == CMD_PROG_FIRST)
    else $error("bad first district command");
  a_wp_high : assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (st_q != H_IDLE) |-> PINS_O.wp_n) else $error("write protect low");
endmodule

//--- src/nrps_pkg.sv
package nrps_pkg;

  // ==========================================================
  // command bytes
  localparam logic [7:0] CMD_READ_SETUP    = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM  = 8'h30;
  localparam logic [7:0] CMD_CACHE_READ    = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST    = 8'h3f;
  localparam logic [7:0] CMD_MULTI_READ    = 8'h60;
  localparam logic [7:0] CMD_PROG_SETUP    = 8'h80;
  localparam logic [7:0] CMD_PROG_SETUP2   = 8'h81;
  localparam logic [7:0] CMD_COL_CHANGE    = 8'h85;
  localparam logic [7:0] CMD_PROG_CONFIRM  = 8'h10;
  localparam logic [7:0] CMD_PROG_FIRST    = 8'h11;
  localparam logic [7:0] CMD_STATUS        = 8'h70;
  localparam logic [7:0] CMD_RESET         = 8'hff;

  // ==========================================================
  // address layout
  localparam int COL_BITS   = 12;
  localparam int ROW_BITS   = 17;
  localparam int PAGE_BITS  = 6;
  localparam int ROW_CYCLES = 3;
  localparam int COL_CYCLES = 2;

  // ==========================================================
  // strobe timing: time in ns, cycles derived at 25 ns clock
  localparam int CLK_PERIOD_NS   = 25;
  localparam int STROBE_LOW_NS   = 25;
  localparam int STROBE_HIGH_NS  = 25;
  localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_SETTLE_NS  = 100;
  localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // host operations
  typedef enum logic [2:0] {
    OP_READ, OP_CACHE_NEXT, OP_CACHE_LAST, OP_MULTI_READ,
    OP_PROGRAM, OP_MULTI_PROG, OP_STATUS, OP_RESET
  } nrps_op_type;

  // kind of one bus cycle on the port
  typedef enum logic [1:0] { CY_CMD, CY_ADDR, CY_WDATA, CY_RDATA } nrps_cyc_type;

  typedef struct packed {
    nrps_op_type            op;
    logic [COL_BITS-1:0]    column;
    logic [ROW_BITS-1:0]    row;
    logic [ROW_BITS-1:0]    row2;
    logic [COL_BITS:0]      count;
  } nrps_req_type;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic [7:0] dq_out;
    logic       dq_oe_n;
  } nrps_pins_type;

endpackage

//--- tb/nrps_host_tb.sv
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; $display("BAD %0t %h %h", $time, g, e); end end
module nrps_host_tb
  import nrps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ========
  // bench signals
  logic          clk, rst, req_valid, rdy, done, rvalid, fail_o, wready, prog_fail, rb;
  logic [7:0]    wdata, rdata, dq;
  nrps_req_type  req;
  nrps_pins_type pins;
  int            fails, num_checks, got_n, busy_n;
  nrps_host i_nrps_host (
    .CLK_SYS_I        (clk),
    .RESET_I          (rst),
    .REQ_VALID_I      (req_valid),
    .REQ_READY_O      (rdy),
    .REQ_I            (req),
    .WDATA_I          (wdata),
    .WDATA_READY_O    (wready),
    .RDATA_O          (rdata),
    .RDATA_VALID_O    (rvalid),
    .STATUS_FAIL_O    (fail_o),
    .DONE_O           (done),
    .DQ_I             (dq),
    .READY_BUSY_OUT_I (rb),
    .PINS_O           (pins)
  );
  nrps_nand_model i_nrps_nand_model (
    .pins_i       (pins),
    .fail_i       (prog_fail),
    .dq_o         (dq),
    .ready_busy_o (rb)
  );
  // 40 MHz
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ========
  // one operation, followed to its done pulse; base 0 skips data checks
  task automatic run_op(input nrps_op_type op, input logic [11:0] col, input logic [16:0] r1, r2,
                        input logic [12:0] cnt, input logic [7:0] base);
    int   k;
    logic wpend;
    k = 0;
    got_n = 0;
    busy_n = 0;
    wpend = 1'b0;
    req = '{op, col, r1, r2, cnt};
    req_valid = 1'b1;
    while (rdy !== 1'b1 && k < 4000)
    begin
      @(posedge clk);
      #2 k++;
    end
    @(posedge clk);
    #2 req_valid = 1'b0;
    while (done !== 1'b1 && k < 4000)
    begin
      @(posedge clk);
      #2 k++;
      // next byte only a cycle after the pulse, never under a live strobe
      if (wpend)
        wdata = wdata + 8'h01;
      wpend = wready;
      busy_n += (rb === 1'b0);
      if (rvalid === 1'b1 && base != 8'h00) `CHK(rdata, 8'(base + col[7:0] + got_n))
      got_n += (rvalid === 1'b1);
    end
    if (k >= 4000)
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  // ========
  // scenarios
  task automatic t_read();
    run_op(OP_READ, 12'h005, 17'h00041, 17'h0, 13'd4, 8'h41);
    `CHK(got_n, 4)
    `CHK(busy_n > 0, 1'b1)
    `CHK(i_nrps_nand_model.row, 17'h00041)
    `CHK(i_nrps_nand_model.col, 12'h009)
  endtask
  // cache chain, last page, then a fresh read straight after
  task automatic t_cache();
    run_op(OP_CACHE_NEXT, 12'h000, 17'h00041, 17'h0, 13'd3, 8'h42);
    `CHK(got_n, 3)
    run_op(OP_CACHE_NEXT, 12'h000, 17'h00041, 17'h0, 13'd3, 8'h43);
    `CHK(i_nrps_nand_model.rd_row, 17'h00043)
    run_op(OP_CACHE_LAST, 12'h000, 17'h00041, 17'h0, 13'd3, 8'h44);
    `CHK(got_n, 3)
    run_op(OP_READ, 12'h000, 17'h00210, 17'h0, 13'd2, 8'h10);
    `CHK(got_n, 2)
    // a chain from the last page of a block must restart as a plain read
    run_op(OP_READ, 12'h000, 17'h0007f, 17'h0, 13'd1, 8'h7f);
    run_op(OP_CACHE_NEXT, 12'h000, 17'h0, 17'h0, 13'd2, 8'h80);
    `CHK(i_nrps_nand_model.row, 17'h00080)
    `CHK(got_n, 2)
  endtask
  // both district orders, same page, unrelated blocks
  task automatic t_multi();
    run_op(OP_MULTI_READ, 12'h000, 17'h00080, 17'h001c0, 13'd2, 8'h80);
    `CHK(i_nrps_nand_model.row[6], 1'b0)
    `CHK(i_nrps_nand_model.row2, 17'h001c0)
    // second district asks for another page; the first district's page must go out
    run_op(OP_MULTI_READ, 12'h000, 17'h000c5, 17'h00407, 13'd2, 8'hc5);
    `CHK(i_nrps_nand_model.row2[5:0], 6'h05)
    `CHK(i_nrps_nand_model.row2, 17'h00405)
    `CHK(busy_n > 0, 1'b1)
  endtask
  // single program, then a multi program the device fails
  task automatic t_prog();
    wdata = 8'hc0;
    run_op(OP_PROGRAM, 12'h010, 17'h00100, 17'h0, 13'd3, 8'h00);
    `CHK(i_nrps_nand_model.mem[8'h10], 8'hc0)
    `CHK(i_nrps_nand_model.mem[8'h12], 8'hc2)
    `CHK(fail_o, 1'b0)
    prog_fail = 1'b1;
    run_op(OP_MULTI_PROG, 12'h000, 17'h00100, 17'h00140, 13'd2, 8'h00);
    `CHK(fail_o, 1'b1)
    `CHK(i_nrps_nand_model.row2, 17'h00140)
  endtask
  // status keeps the failure; reset finishes; no strobe while busy
  task automatic t_status();
    prog_fail = 1'b0;
    run_op(OP_STATUS, 12'h000, 17'h0, 17'h0, 13'd1, 8'h00);
    `CHK(fail_o, 1'b1)
    run_op(OP_RESET, 12'h000, 17'h0, 17'h0, 13'd0, 8'h00);
    `CHK(i_nrps_nand_model.bad, 0)
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ========
  // main sequence
  initial
  begin
    fails = 0;
    num_checks = 0;
    req_valid = 1'b0;
    req = '0;
    wdata = 8'h00;
    prog_fail = 1'b0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #2 rst = 1'b0;
    t_read();
    t_cache();
    t_multi();
    t_prog();
    t_status();
    tally_and_finish();
  end
endmodule

//--- tb/nrps_nand_model.sv
module nrps_nand_model
  import nrps_pkg::*;
#(
  parameter int FETCH_NS = 500,
  parameter int SHORT_NS = 150,
  parameter int PROG_NS  = 900
)
(
  input  nrps_pkg::nrps_pins_type pins_i,
  input  wire logic               fail_i,
  output logic [7:0]              dq_o,
  output logic                    ready_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ========
  // device state
  logic [7:0]          mem [256];
  logic [39:0]         adr;
  logic [ROW_BITS-1:0] row, row2, rd_row;
  logic [COL_BITS-1:0] col;
  logic                have_row, stat_rd, fail_q, col_chg;
  logic [7:0]          setup_cmd;
  int                  na, bad;
  // read setup counts as latched from power-up
  initial
  begin
    have_row = 0;
    stat_rd = 0;
    fail_q = 0;
    col_chg = 0;
    setup_cmd = CMD_READ_SETUP;
    na = 0;
    bad = 0;
    col = '0;
    rd_row = '0;
    dq_o = 8'h5a;
    ready_busy_o = 1'b1;
  end
  // busy at once; the pull-up brings the line back when the work is over
  task automatic go_busy(input int t);
    ready_busy_o = 1'b0;
    ready_busy_o <= #(t) 1'b1;
  endtask
  // ========
  // write strobe: command, address or data byte on the rising edge
  always @(posedge pins_i.we_n)
  begin
    if (!pins_i.ce_n && pins_i.cle)
    begin
      if (!ready_busy_o && pins_i.dq_out != CMD_STATUS && pins_i.dq_out != CMD_RESET)
        bad++;
      stat_rd = (pins_i.dq_out == CMD_STATUS);
      col_chg = (pins_i.dq_out == CMD_COL_CHANGE);
      na = 0;
      // a confirm with no matching setup before it starts nothing
      case (pins_i.dq_out)
        CMD_READ_CONFIRM:
        if (setup_cmd == CMD_READ_SETUP || setup_cmd == CMD_MULTI_READ)
        begin
          if (!pins_i.wp_n)
            bad++;
          rd_row = row;
          have_row = 0;
          go_busy(FETCH_NS);
        end
        CMD_CACHE_READ, CMD_CACHE_LAST:
        begin
          // last page only moves the buffer on; no fetch is started behind it
          rd_row = rd_row + 1'b1;
          col = '0;
          go_busy(SHORT_NS);
        end
        CMD_PROG_FIRST: go_busy(SHORT_NS);
        CMD_PROG_CONFIRM:
        if (setup_cmd == CMD_PROG_SETUP || setup_cmd == CMD_PROG_SETUP2 || setup_cmd == CMD_COL_CHANGE)
        begin
          fail_q = fail_i;
          have_row = 0;
          go_busy(PROG_NS);
        end
        default: ;
      endcase
      // status reads may sit inside a sequence without ending it
      if (pins_i.dq_out != CMD_STATUS)
        setup_cmd = pins_i.dq_out;
    end
    else if (!pins_i.ce_n && pins_i.ale)
    begin
      adr[8*na +: 8] = pins_i.dq_out;
      na++;
      if (col_chg && na == 2)
      begin
        col = adr[11:0];
        col_chg = 0;
      end
      else if (na == 5)
      begin
        if (adr[15:12] != 4'h0 || adr[39:33] != 7'h00)
          bad++;
        col = adr[11:0];
        if (have_row)
          row2 = adr[32:16];
        else
          row = adr[32:16];
        have_row = 1'b1;
      end
    end
    else if (!pins_i.ce_n)
    begin
      mem[col[7:0]] = pins_i.dq_out;
      col++;
    end
  end
  // each falling read strobe hands out a byte; data reads also step the column, status reads do not
  always @(negedge pins_i.read_strobe_n)
  begin
    if (!ready_busy_o)
      bad++;
    if (stat_rd)
      dq_o = {7'h70, fail_q};
    else
    begin
      dq_o = rd_row[7:0] + col[7:0];
      col++;
    end
  end
  // released bus shows the inverse, so a stale byte never looks valid
  always @(posedge pins_i.read_strobe_n)
    dq_o <= #5 ~dq_o;
endmodule
